// [shared/uft_consts.vh]
// constants for the uart fifo trigger and line format block
// assumes an 8-bit register port with a 4-bit offset
`ifndef UFT_CONSTS_VH
`define UFT_CONSTS_VH
// =========================================
// register offsets
`define UFT_OFS_DATA    4'h0
`define UFT_OFS_DIVHI   4'h1
`define UFT_OFS_SETUP   4'h2
`define UFT_OFS_LINE    4'h3
`define UFT_OFS_STATUS  4'h5
`define UFT_OFS_TUNING  4'h8
`define UFT_OFS_ENHANCE 4'h9
`define UFT_OFS_TXTHR   4'hA
`define UFT_OFS_RXTHR   4'hB
// =========================================
// field positions
`define UFT_SU_EN       0
`define UFT_SU_RXRST    1
`define UFT_SU_TXRST    2
`define UFT_LF_STOP     2
`define UFT_LF_PEN      3
`define UFT_LF_EVEN     4
`define UFT_LF_FORCE    5
`define UFT_LF_BREAK    6
`define UFT_LF_DLAB     7
`define UFT_EN_TXCODE   4
// =========================================
// reset values
`define UFT_LINE_RST    8'h00
`define UFT_TUNE_RST    8'h00
`define UFT_ENH_RST     8'h00
`define UFT_THR_RST     8'h01
`define UFT_DIV_RST     8'h01
// =========================================
// trigger tables, one level per byte, code 0 in low byte
`define UFT_TA_RX       32'h0E080401
`define UFT_TA_TX       32'h01010101
`define UFT_TB_RX       32'h1C181008
`define UFT_TB_TX       32'h1E180810
`define UFT_TC_RX       32'h3C381008
`define UFT_TC_TX       32'h38201008
// =========================================
// fifo geometry and stop lengths in half bits
`define UFT_FIFO_W      8
`define UFT_FIFO_D      16
`define UFT_STOP_ONE    3'h2
`define UFT_STOP_ONEH   3'h3
`define UFT_STOP_TWO    3'h4
`endif

// [hdl/uft_fifo.v]
// parameterised first-in first-out buffer
// assumes one clock, synchronous flush, active low reset
`timescale 1ns/1ps
`default_nettype none
module uft_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          clk_in,
  input  wire          rst_n_in,
  input  wire          ce_in,
  input  wire          flush_in,
  input  wire          in_valid_in,
  output wire          in_ready_out,
  input  wire [W-1:0]  in_data_in,
  output wire          out_valid_out,
  input  wire          out_ready_in,
  output wire [W-1:0]  out_data_out,
  output reg  [AW:0]   count_out
);
  reg [W-1:0]  mem [0:D-1];   // storage
  reg [AW-1:0] wp;            // write pointer
  reg [AW-1:0] rp;            // read pointer
  wire         push;
  wire         pop;
  assign in_ready_out  = (count_out != D[AW:0]);
  assign out_valid_out = (count_out != {(AW+1){1'b0}});
  assign out_data_out  = mem[rp];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;
  // =========================================
  // storage write, no reset needed
  always @(posedge clk_in) begin
    if (ce_in && push && !flush_in) begin
      mem[wp] <= in_data_in;
    end
  end
  // =========================================
  // pointers and count
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp        <= {AW{1'b0}};
      rp        <= {AW{1'b0}};
      count_out <= {(AW+1){1'b0}};
    end else if (ce_in) begin
      if (flush_in) begin
        wp        <= {AW{1'b0}};
        rp        <= {AW{1'b0}};
        count_out <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wp <= wp + 1'b1;
        end
        if (pop) begin
          rp <= rp + 1'b1;
        end
        if (push && !pop) begin
          count_out <= count_out + 1'b1;
        end else if (pop && !push) begin
          count_out <= count_out - 1'b1;
        end
      end
    end
  end
endmodule // uft_fifo
`default_nettype wire

// [hdl/uft_top.v]
// uart channel core: fifo setup, trigger levels, line format
// assumes register port on the core clock, serial pins async
`timescale 1ns/1ps
`default_nettype none
`include "uft_consts.vh"
module uft_top (
  input  wire       ref_clk_in,
  input  wire       reset_n_in,
  input  wire       ce_in,
  input  wire [3:0] reg_addr_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       rx_line_in,
  output reg  [7:0] reg_rdata_out,
  output reg        tx_line_out,
  output reg        rx_trigger_out,
  output reg        tx_ready_out,
  output reg        fifo_enabled_out
);
  // shift engine states
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA  = 3'd2;
  localparam ST_PAR   = 3'd3;
  localparam ST_STOP  = 3'd4;
  // =========================================
  // helper functions
  // picks one level byte from a packed table
  function [7:0] pick;
    input [31:0] tbl;
    input [1:0]  code;
    begin
      pick = tbl[{code, 3'b000} +: 8];
    end
  endfunction
  // trigger level for table, code and direction
  function [7:0] trig_level;
    input [1:0] sel;
    input [1:0] code;
    input       is_tx;
    input [7:0] prog;
    begin
      case (sel)
        2'b00:   trig_level = is_tx ? pick(`UFT_TA_TX, code)
                                    : pick(`UFT_TA_RX, code);
        2'b01:   trig_level = is_tx ? pick(`UFT_TB_TX, code)
                                    : pick(`UFT_TB_RX, code);
        2'b10:   trig_level = is_tx ? pick(`UFT_TC_TX, code)
                                    : pick(`UFT_TC_RX, code);
        default: trig_level = prog;
      endcase
    end
  endfunction
  // parity bit over the active data bits
  function par_bit;
    input [7:0] d;
    input [7:0] lf;
    reg   [7:0] m;
    begin
      m = d & (8'hFF >> (2'd3 - lf[1:0]));
      if (lf[`UFT_LF_FORCE]) begin
        par_bit = ~lf[`UFT_LF_EVEN];
      end else begin
        par_bit = (^m) ^ ~lf[`UFT_LF_EVEN];
      end
    end
  endfunction
  // =========================================
  // reset release through two flops
  reg rst_a;
  reg rst_n;
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end
  // serial input synchroniser
  reg rx_s1;
  reg rx_s2;
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else if (ce_in) begin
      rx_s1 <= rx_line_in;
      rx_s2 <= rx_s1;
    end
  end
  // =========================================
  // control registers
  reg [7:0] line_format_reg;       // character format
  reg [7:0] feature_tuning_reg;    // bits 7:6 table select
  reg [7:0] enhanced_feature_reg;  // bit 4 unlocks tx code
  reg [7:0] rx_threshold_reg;      // table d receive level
  reg [7:0] tx_threshold_reg;      // table d transmit level
  reg [7:0] divisor_low_latch;     // half-bit clocks, low
  reg [7:0] divisor_high_latch;    // half-bit clocks, high
  reg [7:0] divisor_fraction_latch; // kept for software
  reg       fifo_en;               // fifos enabled
  reg [1:0] rx_code;               // receive trigger code
  reg [1:0] tx_code;               // transmit trigger code
  reg       rx_flush;              // one-cycle receive flush
  reg       tx_flush;              // one-cycle transmit flush
  reg       ovr_err;               // sticky overrun
  reg       par_err;               // sticky parity error
  reg       frm_err;               // sticky framing error
  wire      dlab = line_format_reg[`UFT_LF_DLAB];
  wire      wr_data = reg_wr_in && reg_addr_in == `UFT_OFS_DATA
                      && !dlab;
  wire      rd_data = reg_rd_in && reg_addr_in == `UFT_OFS_DATA
                      && !dlab;
  wire      rd_stat = reg_rd_in && reg_addr_in == `UFT_OFS_STATUS;
  wire      setup_en = reg_wdata_in[`UFT_SU_EN];
  // =========================================
  // fifo instances
  wire       tx_in_rdy;
  wire       tx_out_vld;
  reg        tx_pop;
  wire [7:0] tx_head;
  wire [4:0] tx_cnt;
  wire       rx_in_rdy;
  wire       rx_out_vld;
  reg        rx_push;
  reg  [7:0] rx_shreg;
  wire [7:0] rx_head;
  wire [4:0] rx_cnt;
  // non-fifo mode keeps a single holding slot
  wire tx_room = tx_in_rdy && (fifo_en || tx_cnt == 5'h00);
  wire rx_room = rx_in_rdy && (fifo_en || rx_cnt == 5'h00);
  uft_fifo #(.W(`UFT_FIFO_W), .D(`UFT_FIFO_D), .AW(4)) u_txf (
    .clk_in        (ref_clk_in),
    .rst_n_in      (rst_n),
    .ce_in         (ce_in),
    .flush_in      (tx_flush),
    .in_valid_in   (wr_data && tx_room),
    .in_ready_out  (tx_in_rdy),
    .in_data_in    (reg_wdata_in),
    .out_valid_out (tx_out_vld),
    .out_ready_in  (tx_pop),
    .out_data_out  (tx_head),
    .count_out     (tx_cnt)
  );
  uft_fifo #(.W(`UFT_FIFO_W), .D(`UFT_FIFO_D), .AW(4)) u_rxf (
    .clk_in        (ref_clk_in),
    .rst_n_in      (rst_n),
    .ce_in         (ce_in),
    .flush_in      (rx_flush),
    .in_valid_in   (rx_push && rx_room),
    .in_ready_out  (rx_in_rdy),
    .in_data_in    (rx_shreg),
    .out_valid_out (rx_out_vld),
    .out_ready_in  (rd_data),
    .out_data_out  (rx_head),
    .count_out     (rx_cnt)
  );
  // =========================================
  // register writes
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      line_format_reg        <= `UFT_LINE_RST;
      feature_tuning_reg     <= `UFT_TUNE_RST;
      enhanced_feature_reg   <= `UFT_ENH_RST;
      rx_threshold_reg       <= `UFT_THR_RST;
      tx_threshold_reg       <= `UFT_THR_RST;
      divisor_low_latch      <= `UFT_DIV_RST;
      divisor_high_latch     <= 8'h00;
      divisor_fraction_latch <= 8'h00;
      fifo_en                <= 1'b0;
      rx_code                <= 2'b00;
      tx_code                <= 2'b00;
      rx_flush               <= 1'b0;
      tx_flush               <= 1'b0;
    end else if (ce_in) begin
      rx_flush <= 1'b0;
      tx_flush <= 1'b0;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `UFT_OFS_DATA: begin
            if (dlab) begin
              divisor_low_latch <= reg_wdata_in;
            end
          end
          `UFT_OFS_DIVHI: begin
            if (dlab) begin
              divisor_high_latch <= reg_wdata_in;
            end
          end
          `UFT_OFS_SETUP: begin
            if (dlab) begin
              divisor_fraction_latch <= reg_wdata_in;
            end else begin
              fifo_en <= setup_en;
              // toggling enable empties both fifos
              rx_flush <= setup_en != fifo_en;
              tx_flush <= setup_en != fifo_en;
              if (setup_en) begin
                rx_code <= reg_wdata_in[7:6];
                if (enhanced_feature_reg[`UFT_EN_TXCODE]) begin
                  tx_code <= reg_wdata_in[5:4];
                end
                if (reg_wdata_in[`UFT_SU_RXRST]) begin
                  rx_flush <= 1'b1;
                end
                if (reg_wdata_in[`UFT_SU_TXRST]) begin
                  tx_flush <= 1'b1;
                end
              end
            end
          end
          `UFT_OFS_LINE:    line_format_reg      <= reg_wdata_in;
          `UFT_OFS_TUNING:  feature_tuning_reg   <= reg_wdata_in;
          `UFT_OFS_ENHANCE: enhanced_feature_reg <= reg_wdata_in;
          `UFT_OFS_TXTHR:   tx_threshold_reg     <= reg_wdata_in;
          `UFT_OFS_RXTHR:   rx_threshold_reg     <= reg_wdata_in;
          default: ;
        endcase
      end
    end
  end
  // =========================================
  // trigger levels and fifo conditions
  wire [7:0] rx_lvl = trig_level(feature_tuning_reg[7:6], rx_code,
                                 1'b0, rx_threshold_reg);
  wire [7:0] tx_lvl = trig_level(feature_tuning_reg[7:6], tx_code,
                                 1'b1, tx_threshold_reg);
  reg  [4:0] tx_prev; // transmit count one cycle back
  wire       tx_below = {3'b000, tx_cnt} < tx_lvl;
  wire       tx_was = {3'b000, tx_prev} >= tx_lvl;
  wire       tx_event = (tx_below && tx_was)
                        || (tx_cnt == 5'h00 && tx_prev != 5'h00);
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_prev          <= 5'h00;
      rx_trigger_out   <= 1'b0;
      tx_ready_out     <= 1'b0;
      fifo_enabled_out <= 1'b0;
    end else if (ce_in) begin
      tx_prev          <= tx_cnt;
      fifo_enabled_out <= fifo_en;
      // level follows current count, stored data untouched
      rx_trigger_out <= fifo_en ? ({3'b000, rx_cnt} >= rx_lvl)
                                : (rx_cnt != 5'h00);
      // set wins over the clear by a data write
      if (tx_event) begin
        tx_ready_out <= 1'b1;
      end else if (wr_data) begin
        tx_ready_out <= 1'b0;
      end
    end
  end
  // =========================================
  // half-bit tick dividers
  wire [15:0] divisor = {divisor_high_latch, divisor_low_latch};
  wire [15:0] div_end = (divisor == 16'h0000) ? 16'h0000
                                              : divisor - 16'h0001;
  reg  [15:0] tx_div;
  reg  [15:0] rx_div;
  reg  [2:0]  tx_st;
  reg  [2:0]  rx_st;
  wire        tx_tick = (tx_st != ST_IDLE) && (tx_div == div_end);
  wire        rx_tick = (rx_st != ST_IDLE) && (rx_div == div_end);
  wire [2:0]  stop_half = !line_format_reg[`UFT_LF_STOP] ? `UFT_STOP_ONE
                        : (line_format_reg[1:0] == 2'b00) ? `UFT_STOP_ONEH
                        : `UFT_STOP_TWO;
  wire [2:0]  last_bit = {1'b0, line_format_reg[1:0]} + 3'd4;
  // =========================================
  // transmitter
  reg [7:0] tx_sh;   // data being shifted
  reg [2:0] tx_bit;  // data bit index
  reg [2:0] tx_rem;  // half bits left in this bit
  reg       tx_par;  // parity for this character
  reg       tx_lvl_bit;
  always @* begin
    case (tx_st)
      ST_START: tx_lvl_bit = 1'b0;
      ST_DATA:  tx_lvl_bit = tx_sh[0];
      ST_PAR:   tx_lvl_bit = tx_par;
      default:  tx_lvl_bit = 1'b1;
    endcase
  end
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_st       <= ST_IDLE;
      tx_div      <= 16'h0000;
      tx_sh       <= 8'h00;
      tx_bit      <= 3'd0;
      tx_rem      <= 3'd0;
      tx_par      <= 1'b0;
      tx_pop      <= 1'b0;
      tx_line_out <= 1'b1;
    end else if (ce_in) begin
      tx_pop      <= 1'b0;
      tx_line_out <= line_format_reg[`UFT_LF_BREAK] ? 1'b0
                                                    : tx_lvl_bit;
      tx_div <= (tx_st == ST_IDLE || tx_tick) ? 16'h0000
                                              : tx_div + 16'h0001;
      case (tx_st)
        ST_IDLE: begin
          if (tx_out_vld && !tx_pop) begin
            tx_pop <= 1'b1;
            tx_sh  <= tx_head;
            tx_par <= par_bit(tx_head, line_format_reg);
            tx_rem <= 3'd2;
            tx_st  <= ST_START;
          end
        end
        default: begin
          if (tx_tick) begin
            if (tx_rem > 3'd1) begin
              tx_rem <= tx_rem - 3'd1;
            end else begin
              tx_rem <= 3'd2;
              case (tx_st)
                ST_START: begin
                  tx_bit <= 3'd0;
                  tx_st  <= ST_DATA;
                end
                ST_DATA: begin
                  tx_sh  <= {1'b0, tx_sh[7:1]};
                  tx_bit <= tx_bit + 3'd1;
                  if (tx_bit == last_bit) begin
                    if (line_format_reg[`UFT_LF_PEN]) begin
                      tx_st <= ST_PAR;
                    end else begin
                      tx_st  <= ST_STOP;
                      tx_rem <= stop_half;
                    end
                  end
                end
                ST_PAR: begin
                  tx_st  <= ST_STOP;
                  tx_rem <= stop_half;
                end
                default: tx_st <= ST_IDLE;
              endcase
            end
          end
        end
      endcase
    end
  end
  // =========================================
  // receiver, samples mid-bit
  reg [2:0] rx_bit;
  reg [2:0] rx_rem;
  reg       rx_par;
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_st    <= ST_IDLE;
      rx_div   <= 16'h0000;
      rx_shreg <= 8'h00;
      rx_bit   <= 3'd0;
      rx_rem   <= 3'd0;
      rx_par   <= 1'b0;
      rx_push  <= 1'b0;
      ovr_err  <= 1'b0;
      par_err  <= 1'b0;
      frm_err  <= 1'b0;
    end else if (ce_in) begin
      rx_push <= 1'b0;
      rx_div  <= (rx_st == ST_IDLE || rx_tick) ? 16'h0000
                                               : rx_div + 16'h0001;
      // status read clears, a new error in the same cycle stays
      if (rd_stat) begin
        ovr_err <= 1'b0;
        par_err <= 1'b0;
        frm_err <= 1'b0;
      end
      if (rx_push && !rx_room) begin
        ovr_err <= 1'b1;
      end
      case (rx_st)
        ST_IDLE: begin
          if (!rx_s2) begin
            rx_rem <= 3'd1;
            rx_st  <= ST_START;
          end
        end
        default: begin
          if (rx_tick) begin
            if (rx_rem > 3'd1) begin
              rx_rem <= rx_rem - 3'd1;
            end else begin
              rx_rem <= 3'd2;
              case (rx_st)
                ST_START: begin
                  rx_bit   <= 3'd0;
                  rx_shreg <= 8'h00;
                  rx_st    <= rx_s2 ? ST_IDLE : ST_DATA;
                end
                ST_DATA: begin
                  rx_shreg <= rx_shreg | ({7'h00, rx_s2} << rx_bit);
                  rx_bit   <= rx_bit + 3'd1;
                  if (rx_bit == last_bit) begin
                    rx_st <= line_format_reg[`UFT_LF_PEN] ? ST_PAR
                                                          : ST_STOP;
                  end
                end
                ST_PAR: begin
                  rx_par <= rx_s2;
                  rx_st  <= ST_STOP;
                end
                default: begin
                  rx_push <= 1'b1;
                  rx_st   <= ST_IDLE;
                  if (!rx_s2) begin
                    frm_err <= 1'b1;
                  end
                  if (line_format_reg[`UFT_LF_PEN] &&
                      rx_par != par_bit(rx_shreg, line_format_reg)) begin
                    par_err <= 1'b1;
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end
  // =========================================
  // register reads
  wire tx_empty = (tx_cnt == 5'h00);
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      case (reg_addr_in)
        `UFT_OFS_DATA:    reg_rdata_out <= dlab ? divisor_low_latch
                                                : rx_head;
        `UFT_OFS_DIVHI:   reg_rdata_out <= dlab ? divisor_high_latch
                                                : 8'h00;
        `UFT_OFS_SETUP:   reg_rdata_out <= dlab ? divisor_fraction_latch
                                                : {fifo_en, fifo_en, 6'h01};
        `UFT_OFS_LINE:    reg_rdata_out <= line_format_reg;
        `UFT_OFS_STATUS:  reg_rdata_out <= {1'b0,
                            tx_empty && tx_st == ST_IDLE, tx_empty,
                            1'b0, frm_err, par_err, ovr_err, rx_out_vld};
        `UFT_OFS_TUNING:  reg_rdata_out <= feature_tuning_reg;
        `UFT_OFS_ENHANCE: reg_rdata_out <= enhanced_feature_reg;
        `UFT_OFS_TXTHR:   reg_rdata_out <= tx_threshold_reg;
        `UFT_OFS_RXTHR:   reg_rdata_out <= rx_threshold_reg;
        default:          reg_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule // uft_top
`default_nettype wire

// [tb/uft_top_props.sv]
// checker for the uft_top register port and transmit line
// assumes a single core clock and bind onto uft_top
`timescale 1ns/1ps
`default_nettype none
module uft_top_props (
  input wire logic       ref_clk_in,
  input wire logic       reset_n_in,
  input wire logic       ce_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       tx_line_out,
  input wire logic       fifo_enabled_out
);
  // =========================================
  // shadow of the line format register
  logic [7:0] lf;                                          // tracked format
  wire        rd = ce_in && reg_rd_in;                     // taken read
  // follow line format writes
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) lf <= 8'h00;
    else if (ce_in && reg_wr_in && reg_addr_in == 4'h3) lf <= reg_wdata_in;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // =========================================
  // properties
  a_break_low: assert property (lf[6] && $past(lf[6]) |-> !tx_line_out)
    else $error("break not low");
  a_line_readback: assert property (rd && reg_addr_in == 4'h3 |=> reg_rdata_out == lf)
    else $error("line format readback");
  a_enable_copy: assert property (ce_in && reg_wr_in && reg_addr_in == 4'h2 && !lf[7]
    |-> ##2 fifo_enabled_out == $past(reg_wdata_in[0], 2)) else $error("fifo enable copy");
  a_setup_status: assert property (rd && reg_addr_in == 4'h2 && !lf[7]
    |=> reg_rdata_out == {fifo_enabled_out, fifo_enabled_out, 6'h01}) else $error("setup status");
  a_divhi_hidden: assert property (rd && reg_addr_in == 4'h1 && !lf[7] |=> reg_rdata_out == 8'h00)
    else $error("divisor seen without access bit");
  a_rdata_hold: assert property (!rd |=> $stable(reg_rdata_out))
    else $error("read data moved");
  a_bit_min: assert property ($changed(tx_line_out) && !lf[6] && !$past(lf[6]) |=> $stable(tx_line_out))
    else $error("line bit too short");
  a_ce_freeze: assert property (!ce_in |=> $stable(tx_line_out) && $stable(fifo_enabled_out))
    else $error("state moved while frozen");
  cover property (lf[6] && $past(lf[6]));
  cover property (rd && reg_addr_in == 4'h3);
  cover property (ce_in && reg_wr_in && reg_addr_in == 4'h2 && reg_wdata_in[0]);
endmodule // uft_top_props
bind uft_top uft_top_props i_props (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .tx_line_out(tx_line_out), .fifo_enabled_out(fifo_enabled_out));
`default_nettype wire

// [tb/uft_peer.sv]
// remote serial device: samples the transmit pin, drives the receive pin
// assumes BT core clocks per bit, frames handed in lsb first
`timescale 1ns/1ps
`default_nettype none
module uft_peer #(parameter int BT = 8) (
  input  wire logic clk_in,
  input  wire logic tx_in,
  output var logic  rx_out
);
  initial rx_out = 1'b1; // idle mark level
  // sample n bits at bit centres, start bit first
  task automatic grab(input int n, output logic [15:0] bits);
    bits = 16'hFFFF;
    @(negedge tx_in);
    repeat (BT / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_in;
      repeat (BT) @(posedge clk_in);
    end
  endtask
  // drive n bits, each for one bit time, then back to mark
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_out <= bits[i];
      repeat (BT) @(posedge clk_in);
    end
    rx_out <= 1'b1;
  endtask
endmodule // uft_peer
`default_nettype wire

// [tb/test_uft_top.sv]
// self-checking bench for uft_top with a serial peer
// assumes divisor 4, so one bit is 8 core clocks
`timescale 1ns/1ps
`default_nettype none
module test_uft_top;
  logic clk, rst_n, ce, wr_s, rd_s, txl, rxl, rtrig, fen, trdy;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, v;
  logic [15:0] f;
  int          n_mismatch, compares, cyc, g0, g1, g2, g3;
  uft_top i_dut (.ref_clk_in(clk), .reset_n_in(rst_n), .ce_in(ce), .reg_addr_in(addr), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_wdata_in(wdata), .rx_line_in(rxl), .reg_rdata_out(rdata), .tx_line_out(txl),
    .rx_trigger_out(rtrig), .tx_ready_out(trdy), .fifo_enabled_out(fen));
  uft_peer #(.BT(8)) i_peer (.clk_in(clk), .tx_in(txl), .rx_out(rxl));
  // =========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_mismatch++;
      close_out();
    end
  end
  // =========================================
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // expected frame: start, data lsb first, parity, then mark
  function automatic logic [15:0] frame(input logic [7:0] lf, input logic [7:0] d);
    int wl;
    logic [15:0] r;
    wl = 5 + lf[1:0];
    r = 16'hFFFE;
    for (int i = 0; i < wl; i++) r[i+1] = d[i];
    if (lf[3]) r[wl+1] = lf[5] ? ~lf[4] : ^(d & (8'hFF >> (8 - wl))) ^ ~lf[4];
    return r;
  endfunction
  // cycles between two start edges of back to back characters
  task automatic gap(input logic [7:0] lf, output int g);
    time t0;
    wr(4'h3, lf);
    wr(4'h0, 8'hFF);
    wr(4'h0, 8'hFF);
    @(negedge txl);
    t0 = $time;
    @(negedge txl);
    g = int'(($time - t0) / 10);
    repeat (120) @(posedge clk);
  endtask
  // =========================================
  // scenarios
  task automatic t_regs;
    chk("tx idle", txl, 1'b1);
    chk("fifo off", fen, 1'b0);
    rd(4'h3, v);
    chk("line reset", v, 8'h00);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(4'h3, 8'h1B << i);
      rd(4'h3, v);
      chk("line rw", v, 8'h1B << i);
    end
    wr(4'h3, 8'h83);
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h00);
    rd(4'h0, v);
    chk("divisor low", v, 8'h04);
    wr(4'h3, 8'h03);
    rd(4'h1, v);
    chk("divisor hidden", v, 8'h00);
    wr(4'h2, 8'hC0);
    rd(4'h2, v);
    chk("enable needed", v, 8'h01);
    wr(4'h2, 8'h01);
    repeat (2) @(posedge clk);
    rd(4'h2, v);
    chk("fifo on", v, 8'hC1);
    wr(4'h3, 8'h43);
    repeat (20) @(posedge clk);
    chk("break", txl, 1'b0);
    wr(4'h3, 8'h03);
    repeat (2) @(posedge clk);
    chk("break off", txl, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_tx;
    logic [7:0] fm [7] = '{8'h03, 8'h0B, 8'h1B, 8'h2B, 8'h3B, 8'h08, 8'h19};
    foreach (fm[i]) begin
      wr(4'h3, fm[i]);
      wr(4'h0, 8'hA6);
      @(negedge clk);
      chk("tx busy", trdy, 1'b0);
      i_peer.grab(12, f);
      chk("tx frame", f, frame(fm[i], 8'hA6));
      chk("tx ready", trdy, 1'b1);
    end
    gap(8'h00, g0);
    gap(8'h04, g1);
    gap(8'h03, g2);
    gap(8'h07, g3);
    chk("stop half", g1 - g0, 16'd4);
    chk("stop two", g3 - g2, 16'd8);
    chk("word len", g2 - g0, 16'd24);
    $display("test tx done");
  endtask
  task automatic t_rx;
    wr(4'h3, 8'h1B);
    i_peer.send(frame(8'h1B, 8'h5C), 11);
    repeat (6) @(posedge clk);
    rd(4'h5, v);
    chk("good parity", v & 8'h05, 8'h01);
    rd(4'h0, v);
    chk("rx data", v, 8'h5C);
    f = frame(8'h1B, 8'h5C);
    f[9] = ~f[9];
    i_peer.send(f, 11);
    repeat (6) @(posedge clk);
    rd(4'h5, v);
    chk("bad parity", v & 8'h05, 8'h05);
    rd(4'h0, v);
    wr(4'h2, 8'h41);
    for (int i = 0; i < 4; i++) begin
      chk("rx below", rtrig, 1'b0);
      i_peer.send(frame(8'h1B, 8'h30 + i), 11);
      repeat (6) @(posedge clk);
    end
    chk("rx level 4", rtrig, 1'b1);
    wr(4'h8, 8'hC0);
    wr(4'hB, 8'h02);
    rd(4'h0, v);
    chk("kept data", v, 8'h30);
    repeat (3) @(posedge clk);
    chk("table d on", rtrig, 1'b1);
    rd(4'h0, v);
    rd(4'h0, v);
    repeat (3) @(posedge clk);
    chk("table d off", rtrig, 1'b0);
    $display("test rx done");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // =========================================
  // main sequence
  initial begin
    {rst_n, wr_s, rd_s, addr, wdata} = '0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_tx();
    t_rx();
    close_out();
  end
endmodule // test_uft_top
`default_nettype wire
